/* File: rtl/lsc_module_end.sv */
`timescale 1ns/1ps
// ==========================================================
// module end: select gating, reset filter, init, power mode,
// interrupt and presence, two-wire slave with small map
module lsc_module_end (
	input  wire logic clk_i,		// 200 MHz clock
	input  wire logic reset_n_i,		// power-on reset
	input  wire logic fault_i,		// internal fault event
	output logic      low_power_select_o,	// high in low power
	lsc_if.dev        bus			// module pins
);

	// ==========================================================
	// pin sampling and bus events
	logic scl_q_r;				// scl one cycle back
	logic sda_q_r;				// sda one cycle back
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// ==========================================================
	// reset filter state
	logic        rst_s1_r;			// synchroniser first
	logic        rst_s2_r;			// synchroniser second
	logic [12:0] low_cnt_r;			// cycles reset held low
	logic [12:0] low_cnt_nxt;
	logic        in_rst_r;			// module reset active
	logic        in_rst_nxt;

	// ==========================================================
	// map, init and pin state
	logic [7:0]  rw_mem_r [2];		// control, scratch
	logic [7:0]  rw_mem_nxt [2];
	logic [1:0]  flags_r;			// sticky event flags
	logic [1:0]  flags_nxt;
	logic [1:0]  flag_set;
	logic [12:0] init_cnt_r;		// init countdown
	logic [12:0] init_cnt_nxt;
	logic        not_ready_r;		// init pending
	logic        not_ready_nxt;
	logic        lp_r;			// low power active
	logic        lp_nxt;
	logic        int_oe_r;			// interrupt pull-down
	logic        int_oe_nxt;
	logic        prs_oe_r;			// presence pull-down

	// ==========================================================
	// two-wire slave state
	lsc_pkg::lsc_slv_state_t st_r;
	lsc_pkg::lsc_slv_state_t st_nxt;
	logic [3:0]  cnt_r;			// bit count in byte
	logic [3:0]  cnt_nxt;
	logic [7:0]  sh_r;			// shift register
	logic [7:0]  sh_nxt;
	logic [7:0]  idx_r;			// map index pointer
	logic [7:0]  idx_nxt;
	logic        rw_r;			// read transfer
	logic        rw_nxt;
	logic        idx_done_r;		// index byte taken
	logic        idx_done_nxt;
	logic        nack_r;			// master declined byte
	logic        nack_nxt;
	logic        sda_oe_r;			// sda pull-down
	logic        sda_oe_nxt;
	logic        wr_en;			// map write strobe
	logic        flag_rd;			// flags byte read
	logic        load;			// fetch next tx byte
	logic [7:0]  rd_byte;

	// ==========================================================
	// bus event decode, pins are synchronous to clk_i
	assign scl_rise  = bus.scl & ~scl_q_r;
	assign scl_fall  = ~bus.scl & scl_q_r;
	assign bus_start = bus.scl & scl_q_r & sda_q_r & ~bus.sda;
	assign bus_stop  = bus.scl & scl_q_r & ~sda_q_r & bus.sda;

	// pins only ever pull low or float
	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_int_o  = 1'b0;
	assign bus.dev_prs_o  = 1'b0;
	assign bus.dev_sda_oe = sda_oe_r;
	assign bus.dev_int_oe = int_oe_r;
	assign bus.dev_prs_oe = prs_oe_r;
	assign low_power_select_o = lp_r;

	// ==========================================================
	// reset filter: counts low cycles, short glitches drop out
	always_comb begin
		low_cnt_nxt = low_cnt_r;
		in_rst_nxt  = 1'b0;
		if (rst_s2_r) begin
			low_cnt_nxt = 13'h0000;
		end else if (low_cnt_r != lsc_pkg::RESET_MIN_CYC) begin
			low_cnt_nxt = low_cnt_r + 13'h0001;
		end else begin
			in_rst_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1_r  <= 1'b1;
			rst_s2_r  <= 1'b1;
			low_cnt_r <= 13'h0000;
			in_rst_r  <= 1'b0;
			scl_q_r   <= 1'b1;
			sda_q_r   <= 1'b1;
		end else begin
			rst_s1_r  <= bus.module_reset_n;
			rst_s2_r  <= rst_s1_r;
			low_cnt_r <= low_cnt_nxt;
			in_rst_r  <= in_rst_nxt;
			scl_q_r   <= bus.scl;
			sda_q_r   <= bus.sda;
		end
	end

	// ==========================================================
	// map read mux, out of range indices read zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx_r)
			lsc_pkg::IDX_STATUS: begin
				rd_byte[lsc_pkg::ST_NOT_READY]  = not_ready_r;
				rd_byte[lsc_pkg::ST_HIGH_POWER] = ~lp_r;
				rd_byte[lsc_pkg::ST_INIT_SW] =
					bus.init_control_select;
			end
			lsc_pkg::IDX_FLAGS:   rd_byte = {6'h00, flags_r};
			lsc_pkg::IDX_CONTROL: rd_byte = rw_mem_r[0];
			lsc_pkg::IDX_SCRATCH: rd_byte = rw_mem_r[1];
			default:              rd_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// map, init countdown, power mode and interrupt
	always_comb begin
		rw_mem_nxt    = rw_mem_r;
		init_cnt_nxt  = init_cnt_r;
		not_ready_nxt = not_ready_r;
		flag_set      = {fault_i, 1'b0};
		if (init_cnt_r == 13'h0001) begin
			not_ready_nxt = 1'b0;
			flag_set[lsc_pkg::FL_RESET_DONE] = 1'b1;
		end
		if (init_cnt_r != 13'h0000) begin
			init_cnt_nxt = init_cnt_r - 13'h0001;
		end
		// a set arriving with the read-clear survives
		flags_nxt = (flag_rd ? 2'b00 : flags_r) | flag_set;
		if (wr_en && idx_r[7:1] == lsc_pkg::IDX_CONTROL[7:1]) begin
			rw_mem_nxt[idx_r[0]] = sh_r;
		end
		if (in_rst_r) begin
			rw_mem_nxt[0] = lsc_pkg::CONTROL_RST;
			rw_mem_nxt[1] = lsc_pkg::SCRATCH_RST;
			flags_nxt     = 2'b00;
			init_cnt_nxt  = lsc_pkg::INIT_CYC;
			not_ready_nxt = 1'b1;
		end
		// software control waits for the enable bit
		if (bus.init_control_select) begin
			lp_nxt = not_ready_r |
				~rw_mem_r[0][lsc_pkg::CT_HP_ENABLE];
		end else begin
			lp_nxt = not_ready_r;
		end
		// no interrupt while init pending, status not valid yet
		int_oe_nxt = ~not_ready_r & (|flags_r);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rw_mem_r[0] <= lsc_pkg::CONTROL_RST;
			rw_mem_r[1] <= lsc_pkg::SCRATCH_RST;
			flags_r     <= 2'b00;
			init_cnt_r  <= lsc_pkg::INIT_CYC;
			not_ready_r <= 1'b1;
			lp_r        <= 1'b1;
			int_oe_r    <= 1'b0;
			prs_oe_r    <= 1'b1;
		end else begin
			rw_mem_r    <= rw_mem_nxt;
			flags_r     <= flags_nxt;
			init_cnt_r  <= init_cnt_nxt;
			not_ready_r <= not_ready_nxt;
			lp_r        <= lp_nxt | in_rst_r;
			int_oe_r    <= int_oe_nxt;
			prs_oe_r    <= 1'b1;
		end
	end

	// ==========================================================
	// two-wire slave: shift on scl rise, drive on scl fall
	always_comb begin
		st_nxt       = st_r;
		cnt_nxt      = cnt_r;
		sh_nxt       = sh_r;
		idx_nxt      = idx_r;
		rw_nxt       = rw_r;
		idx_done_nxt = idx_done_r;
		nack_nxt     = nack_r;
		sda_oe_nxt   = sda_oe_r;
		wr_en        = 1'b0;
		flag_rd      = 1'b0;
		load         = 1'b0;
		if (bus.module_select_n || in_rst_r) begin
			st_nxt     = lsc_pkg::S_IDLE;
			sda_oe_nxt = 1'b0;
		end else if (bus_start) begin
			st_nxt       = lsc_pkg::S_ADDR;
			cnt_nxt      = 4'h0;
			idx_done_nxt = 1'b0;
			sda_oe_nxt   = 1'b0;
		end else if (bus_stop) begin
			st_nxt     = lsc_pkg::S_IDLE;
			sda_oe_nxt = 1'b0;
		end else begin
			unique case (st_r)
				lsc_pkg::S_IDLE: begin
					sda_oe_nxt = 1'b0;	// wait for start
				end
				lsc_pkg::S_ADDR,
				lsc_pkg::S_INDEX,
				lsc_pkg::S_WDATA: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], bus.sda};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall &&
						cnt_r == lsc_pkg::BYTE_BITS) begin
						cnt_nxt    = 4'h0;
						st_nxt     = lsc_pkg::S_ACK;
						sda_oe_nxt = 1'b1;	// acknowledge
						if (st_r == lsc_pkg::S_ADDR) begin
							rw_nxt = sh_r[0];
							// other address: stay silent
							if (sh_r[7:1] != lsc_pkg::DEV_ADDR) begin
								st_nxt     = lsc_pkg::S_IDLE;
								sda_oe_nxt = 1'b0;
							end
						end else if (st_r == lsc_pkg::S_INDEX) begin
							idx_nxt      = sh_r;
							idx_done_nxt = 1'b1;
						end else begin
							wr_en   = 1'b1;
							idx_nxt = idx_r + 8'h01;
						end
					end
				end
				lsc_pkg::S_ACK: begin
					if (scl_fall) begin
						sda_oe_nxt = 1'b0;
						if (rw_r) begin
							load = 1'b1;
						end else if (idx_done_r) begin
							st_nxt = lsc_pkg::S_WDATA;
						end else begin
							st_nxt = lsc_pkg::S_INDEX;
						end
					end
				end
				lsc_pkg::S_TX: begin
					if (scl_fall) begin
						if (cnt_r == lsc_pkg::LAST_BIT) begin
							sda_oe_nxt = 1'b0;	// free for ack
							st_nxt     = lsc_pkg::S_TXACK;
						end else begin
							sh_nxt     = {sh_r[6:0], 1'b0};
							cnt_nxt    = cnt_r + 4'h1;
							sda_oe_nxt = ~sh_r[6];
						end
					end
				end
				lsc_pkg::S_TXACK: begin
					if (scl_rise) begin
						nack_nxt = bus.sda;
					end else if (scl_fall) begin
						if (nack_r) begin
							st_nxt = lsc_pkg::S_IDLE;
						end else begin
							load = 1'b1;
						end
					end
				end
				default: begin			// illegal code
					st_nxt     = lsc_pkg::S_IDLE;
					sda_oe_nxt = 1'b0;
				end
			endcase
		end
		// fetch next byte, reading flags clears them
		if (load) begin
			sh_nxt     = rd_byte;
			flag_rd    = (idx_r == lsc_pkg::IDX_FLAGS);
			idx_nxt    = idx_r + 8'h01;
			sda_oe_nxt = ~rd_byte[7];
			cnt_nxt    = 4'h0;
			st_nxt     = lsc_pkg::S_TX;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r       <= lsc_pkg::S_IDLE;
			cnt_r      <= 4'h0;
			sh_r       <= 8'h00;
			idx_r      <= 8'h00;
			rw_r       <= 1'b0;
			idx_done_r <= 1'b0;
			nack_r     <= 1'b0;
			sda_oe_r   <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			cnt_r      <= cnt_nxt;
			sh_r       <= sh_nxt;
			idx_r      <= idx_nxt;
			rw_r       <= rw_nxt;
			idx_done_r <= idx_done_nxt;
			nack_r     <= nack_nxt;
			sda_oe_r   <= sda_oe_nxt;
		end
	end

endmodule

/* File: rtl/lsc_pkg.sv */
// Summary of operation
// - answer the bus only while selected
// - host gives each module its own select
// - long reset low restores all defaults; the map index idx_r keeps its value
// - host ignores status until reset completes
// - completion shown by interrupt, not-ready cleared
// - power-up posts completion without reset pulse
// - software control holds low power until enabled
// - hardware control enters high power when ready
// - host holds init control level constant
// - undriven init control reads high, software
// - interrupt low flags fault or critical status
// - host reads memory map to find source
// - interrupt only pulls low or releases
// - inserted module grounds the presence line
// - memory map reached only over two-wire bus
package lsc_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_MHZ       = 200;	// clk_i rate
	localparam int RESET_MIN_NS  = 10000;	// least reset low time
	localparam int RESET_HOLD_NS = 20000;	// host reset pulse length
	localparam int INIT_NS       = 2000;	// management init time
	localparam int QUARTER_NS    = 625;	// quarter of a bus bit
	// least times round up to whole cycles
	localparam logic [12:0] RESET_MIN_CYC =
		13'((RESET_MIN_NS * CLK_MHZ + 999) / 1000);
	localparam logic [12:0] RESET_HOLD_CYC =
		13'((RESET_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [12:0] INIT_CYC =
		13'((INIT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  QUARTER_CYC =
		8'((QUARTER_NS * CLK_MHZ + 999) / 1000);

	// ==========================================================
	// two-wire bus
	localparam logic [6:0] DEV_ADDR = 7'h50;	// module bus address
	localparam logic [3:0] BYTE_BITS = 4'h8;	// data bits per byte
	localparam logic [3:0] LAST_BIT  = 4'h7;	// last data bit index

	// ==========================================================
	// memory map
	localparam logic [7:0] IDX_STATUS  = 8'h00;	// read only
	localparam logic [7:0] IDX_FLAGS   = 8'h01;	// clear on read
	localparam logic [7:0] IDX_CONTROL = 8'h02;	// read/write
	localparam logic [7:0] IDX_SCRATCH = 8'h03;	// read/write
	localparam int ST_NOT_READY  = 0;	// init still pending
	localparam int ST_HIGH_POWER = 1;	// high power active
	localparam int ST_INIT_SW    = 2;	// software init control
	localparam int FL_RESET_DONE = 0;	// reset completed
	localparam int FL_FAULT      = 1;	// operational fault seen
	localparam int CT_HP_ENABLE  = 0;	// software high power
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] SCRATCH_RST = 8'h00;

	// ==========================================================
	// state machines
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_ADDR  = 3'h1,
		S_INDEX = 3'h2,
		S_WDATA = 3'h3,
		S_ACK   = 3'h4,
		S_TX    = 3'h5,
		S_TXACK = 3'h6
	} lsc_slv_state_t;

	typedef enum logic [1:0] {
		M_IDLE  = 2'h0,
		M_START = 2'h1,
		M_BIT   = 2'h2,
		M_STOP  = 2'h3
	} lsc_mst_state_t;

endpackage

/* File: rtl/lsc_if.sv */
`timescale 1ns/1ps
// ==========================================================
// low speed pins between host board and module
interface lsc_if;
	logic scl;			// resolved serial clock
	logic sda;			// resolved serial data
	logic interrupt_n;		// resolved interrupt line
	logic module_present_n;		// resolved presence line
	logic init_control_select;	// resolved init mode line
	logic module_select_n;		// host driven select
	logic module_reset_n;		// host driven reset
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic host_init_o;
	logic host_init_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic dev_int_o;
	logic dev_int_oe;
	logic dev_prs_o;
	logic dev_prs_oe;

	// open drain lines, board pull-ups give the high level
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) |
		(dev_sda_oe & ~dev_sda_o));
	assign interrupt_n = ~(dev_int_oe & ~dev_int_o);
	assign module_present_n = ~(dev_prs_oe & ~dev_prs_o);
	// module pull-up wins when host leaves it undriven
	assign init_control_select = host_init_oe ? host_init_o : 1'b1;

	modport dev (
		input  scl, sda, module_select_n, module_reset_n,
		input  init_control_select,
		output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe,
		output dev_prs_o, dev_prs_oe
	);
	modport host (
		input  scl, sda, interrupt_n, module_present_n,
		output module_select_n, module_reset_n,
		output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
		output host_init_o, host_init_oe
	);
endinterface

/* File: rtl/lsc_host_end.sv */
`timescale 1ns/1ps
// ==========================================================
// host end: select, reset pulse, init strap, two-wire master
module lsc_host_end (
	input  wire logic       clk_i,		// 200 MHz clock
	input  wire logic       reset_n_i,	// board reset
	input  wire logic       hw_init_i,	// strap: hardware init
	input  wire logic       reset_req_i,	// pulse module reset
	input  wire logic       cmd_valid_i,	// map access request
	input  wire logic       cmd_write_i,	// 1 write, 0 read
	input  wire logic [7:0] cmd_index_i,	// map index
	input  wire logic [7:0] cmd_data_i,	// write data
	output logic            cmd_ready_o,	// request taken
	output logic            rsp_valid_o,	// one cycle answer
	output logic            rsp_error_o,	// no acknowledge
	output logic [7:0]      rsp_data_o,	// read data
	output logic            status_valid_o,	// status trustworthy
	output logic            irq_o,		// interrupt seen
	output logic            present_o,	// module inserted
	lsc_if.host             bus		// module pins
);

	// ==========================================================
	// pin control state
	logic        strap_done_r;		// strap captured
	logic        hw_init_r;			// captured strap
	logic [12:0] rst_cnt_r;			// reset pulse timer
	logic [12:0] rst_cnt_nxt;
	logic        busy_r;			// waiting for completion
	logic        busy_nxt;
	logic        irq_r;
	logic        prs_r;
	logic        rst_pin_r;
	logic        status_ok_r;		// registered copy of ~busy

	// ==========================================================
	// master state
	lsc_pkg::lsc_mst_state_t ms_r;
	lsc_pkg::lsc_mst_state_t ms_nxt;
	logic [2:0] step_r;			// step of the sequence
	logic [2:0] step_nxt;
	logic [1:0] q_r;			// quarter within a bit
	logic [1:0] q_nxt;
	logic [7:0] tick_r;			// quarter timer
	logic [7:0] tick_nxt;
	logic [3:0] bit_r;			// 0..7 data, 8 ack
	logic [3:0] bit_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic [7:0] rx_r;
	logic [7:0] rx_nxt;
	logic       wr_r;
	logic       wr_nxt;
	logic [7:0] idx_r;
	logic [7:0] idx_nxt;
	logic [7:0] dat_r;
	logic [7:0] dat_nxt;
	logic       err_r;
	logic       err_nxt;
	logic       scl_oe_r;
	logic       scl_oe_nxt;
	logic       sda_oe_r;
	logic       sda_oe_nxt;
	logic       sel_n_r;
	logic       sel_n_nxt;
	logic       rdy_r;
	logic       rdy_nxt;
	logic       rv_r;
	logic       rv_nxt;
	logic [7:0] rdat_r;
	logic [7:0] rdat_nxt;
	logic       rerr_r;
	logic       rerr_nxt;
	logic       advance;
	logic [2:0] step_up;

	assign bus.host_scl_o      = 1'b0;
	assign bus.host_sda_o      = 1'b0;
	assign bus.host_init_o     = 1'b0;
	assign bus.host_scl_oe     = scl_oe_r;
	assign bus.host_sda_oe     = sda_oe_r;
	assign bus.host_init_oe    = hw_init_r;
	assign bus.module_select_n = sel_n_r;
	assign bus.module_reset_n  = rst_pin_r;
	assign cmd_ready_o    = rdy_r;
	assign rsp_valid_o    = rv_r;
	assign rsp_error_o    = rerr_r;
	assign rsp_data_o     = rdat_r;
	assign status_valid_o = status_ok_r;
	assign irq_o          = irq_r;
	assign present_o      = prs_r;

	// ==========================================================
	// reset pulse and completion wait
	always_comb begin
		rst_cnt_nxt = rst_cnt_r;
		busy_nxt    = busy_r;
		if (rst_cnt_r != 13'h0000) begin
			rst_cnt_nxt = rst_cnt_r - 13'h0001;
		end else if (reset_req_i && ms_r == lsc_pkg::M_IDLE) begin
			rst_cnt_nxt = lsc_pkg::RESET_HOLD_CYC;
			busy_nxt    = 1'b1;
		end else if (!bus.interrupt_n) begin
			busy_nxt = 1'b0;
		end
	end

	// strap caught once after release, then held constant
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_done_r <= 1'b0;
			hw_init_r    <= 1'b0;
			rst_cnt_r    <= 13'h0000;
			busy_r       <= 1'b1;
			status_ok_r  <= 1'b0;
			irq_r        <= 1'b0;
			prs_r        <= 1'b0;
			rst_pin_r    <= 1'b1;
		end else begin
			strap_done_r <= 1'b1;
			if (!strap_done_r) begin
				hw_init_r <= hw_init_i;
			end
			rst_cnt_r <= rst_cnt_nxt;
			busy_r    <= busy_nxt;
			status_ok_r <= ~busy_nxt;
			irq_r     <= ~bus.interrupt_n;
			prs_r     <= ~bus.module_present_n;
			rst_pin_r <= (rst_cnt_nxt == 13'h0000);
		end
	end

	// ==========================================================
	// master: sequence of start, bytes and stop per request
	assign step_up = step_r + 3'h1;
	always_comb begin
		ms_nxt = ms_r;  step_nxt = step_r;  q_nxt = q_r;
		tick_nxt = tick_r;  bit_nxt = bit_r;  tx_nxt = tx_r;
		rx_nxt = rx_r;  wr_nxt = wr_r;  idx_nxt = idx_r;
		dat_nxt = dat_r;  err_nxt = err_r;  rv_nxt = 1'b0;
		scl_oe_nxt = scl_oe_r;  sda_oe_nxt = sda_oe_r;
		sel_n_nxt = sel_n_r;  rdat_nxt = rdat_r;
		rerr_nxt = rerr_r;  advance = 1'b0;
		rdy_nxt = (ms_r == lsc_pkg::M_IDLE) && rst_cnt_r == 13'h0000;
		if (ms_r == lsc_pkg::M_IDLE) begin
			if (cmd_valid_i && rdy_r) begin
				wr_nxt = cmd_write_i;  idx_nxt = cmd_index_i;
				dat_nxt = cmd_data_i;  err_nxt = 1'b0;
				sel_n_nxt = 1'b0;
				step_nxt = 3'h0;  q_nxt = 2'h0;
				tick_nxt = lsc_pkg::QUARTER_CYC;
				ms_nxt = lsc_pkg::M_START;  rdy_nxt = 1'b0;
			end
		end else if (tick_r != 8'h00) begin
			tick_nxt = tick_r - 8'h01;
		end else begin
			tick_nxt = lsc_pkg::QUARTER_CYC;
			q_nxt    = q_r + 2'h1;
			unique case (ms_r)
				lsc_pkg::M_START: begin
					sda_oe_nxt = (q_r >= 2'h2);
					scl_oe_nxt = (q_r == 2'h3);
					advance    = (q_r == 2'h3);
				end
				lsc_pkg::M_BIT: begin
					if (q_r == 2'h0) begin
						sda_oe_nxt = (bit_r != lsc_pkg::BYTE_BITS)
							& ~tx_r[7];
					end
					scl_oe_nxt = (q_r == 2'h3) | (q_r == 2'h0);
					if (q_r == 2'h2 && bit_r != lsc_pkg::BYTE_BITS)
						rx_nxt = {rx_r[6:0], bus.sda};
					// last read byte is declined on purpose
					if (q_r == 2'h2 && bit_r == lsc_pkg::BYTE_BITS &&
						bus.sda && !(!wr_r && step_r == 3'h5))
						err_nxt = 1'b1;
					if (q_r == 2'h3) begin
						tx_nxt  = {tx_r[6:0], 1'b1};
						bit_nxt = bit_r + 4'h1;
						if (bit_r == lsc_pkg::BYTE_BITS) begin
							advance = ~err_nxt;
							if (err_nxt) ms_nxt = lsc_pkg::M_STOP;
						end
					end
				end
				lsc_pkg::M_STOP: begin
					sda_oe_nxt = (q_r <= 2'h1);
					scl_oe_nxt = (q_r == 2'h0);
					if (q_r == 2'h3) begin
						ms_nxt = lsc_pkg::M_IDLE;  sel_n_nxt = 1'b1;
						rv_nxt = 1'b1;  rdat_nxt = rx_r;
						rerr_nxt = err_r;
					end
				end
				default: ms_nxt = lsc_pkg::M_IDLE;
			endcase
		end
		if (advance) begin			// next step of sequence
			step_nxt = step_up;  bit_nxt = 4'h0;
			ms_nxt = lsc_pkg::M_BIT;
			unique case (step_up)
				3'h1: tx_nxt = {lsc_pkg::DEV_ADDR, 1'b0};
				3'h2: tx_nxt = idx_r;
				3'h3: tx_nxt = dat_r;
				3'h4: tx_nxt = {lsc_pkg::DEV_ADDR, 1'b1};
				default: tx_nxt = 8'hFF;	// read byte
			endcase
			if (wr_r ? step_up == 3'h4 : step_up == 3'h6)
				ms_nxt = lsc_pkg::M_STOP;
			if (!wr_r && step_up == 3'h3) ms_nxt = lsc_pkg::M_START;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ms_r <= lsc_pkg::M_IDLE;  step_r <= 3'h0;  q_r <= 2'h0;
			tick_r <= 8'h00;  bit_r <= 4'h0;  tx_r <= 8'h00;
			rx_r <= 8'h00;  wr_r <= 1'b0;  idx_r <= 8'h00;
			dat_r <= 8'h00;  err_r <= 1'b0;  scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;  sel_n_r <= 1'b1;  rdy_r <= 1'b0;
			rv_r <= 1'b0;  rdat_r <= 8'h00;  rerr_r <= 1'b0;
		end else begin
			ms_r <= ms_nxt;  step_r <= step_nxt;  q_r <= q_nxt;
			tick_r <= tick_nxt;  bit_r <= bit_nxt;  tx_r <= tx_nxt;
			rx_r <= rx_nxt;  wr_r <= wr_nxt;  idx_r <= idx_nxt;
			dat_r <= dat_nxt;  err_r <= err_nxt;
			scl_oe_r <= scl_oe_nxt;  sda_oe_r <= sda_oe_nxt;
			sel_n_r <= sel_n_nxt;  rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;  rdat_r <= rdat_nxt;
			rerr_r <= rerr_nxt;
		end
	end

endmodule

/* File: bench/lsc_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// pin level checks on the joined low speed pins
module lsc_chk (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic scl,
	input wire logic interrupt_n,
	input wire logic module_present_n,
	input wire logic init_control_select,
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic host_init_oe,
	input wire logic dev_sda_oe,
	input wire logic dev_int_o,
	input wire logic dev_int_oe
);
	logic [12:0] low_r;	// cycles the module reset pin is low
	logic [12:0] low_nxt;

	// saturating, so a held reset never wraps to a short one
	always_comb begin
		low_nxt = module_reset_n ? 13'h0000 : low_r + 13'(~&low_r);
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_r <= 13'h0000;
		end else begin
			low_r <= low_nxt;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// ==========================================================
	// assertions
	a_desel_quiet: assert property (module_select_n
		&& $past(module_select_n) |-> !dev_sda_oe)
		else $error("sda driven while deselected");
	a_sda_after_fall: assert property ($rose(dev_sda_oe)
		|-> !scl && !module_select_n) else $error("sda taken off cycle");
	a_long_reset_idle: assert property (low_r >= 13'h07E0
		|-> !dev_int_oe && !dev_sda_oe) else $error("active in reset");
	a_reset_done_int: assert property ($rose(module_reset_n)
		&& low_r >= 13'h07D0 |-> ##[398:415] !interrupt_n)
		else $error("no completion after reset");
	a_power_up_int: assert property ($rose(reset_n_i)
		|-> ##[395:415] !interrupt_n) else $error("no power-up post");
	a_int_pull_only: assert property (!dev_int_o)
		else $error("interrupt driven high");
	a_present_low: assert property (!module_present_n)
		else $error("presence not grounded");
	a_init_pullup: assert property (!host_init_oe
		|-> init_control_select) else $error("init line not pulled up");
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// both ends joined, host user side driven by the bench
module tb_top;
	logic       clk_i = 1'b0;
	logic       reset_n_i = 1'b0;
	logic       fault_i = 1'b0;
	logic       hw_init_i = 1'b0;
	logic       reset_req_i = 1'b0;
	logic       cmd_valid_i = 1'b0;
	logic       cmd_write_i = 1'b0;
	logic [7:0] cmd_index_i = 8'h00;
	logic [7:0] cmd_data_i = 8'h00;
	logic       low_power_select_o, cmd_ready_o, rsp_valid_o;
	logic       rsp_error_o, status_valid_o, irq_o, present_o;
	logic [7:0] rsp_data_o;
	int         err_total = 0;
	int         checks = 0;
	int         cyc = 0;	// each read costs near 20k cycles

	lsc_if bus_if ();
	always #2.5 clk_i = ~clk_i;
	lsc_module_end u_lsc_module_end (.clk_i, .reset_n_i, .fault_i,
		.low_power_select_o, .bus(bus_if));
	lsc_host_end u_lsc_host_end (.clk_i, .reset_n_i, .hw_init_i,
		.reset_req_i, .cmd_valid_i, .cmd_write_i, .cmd_index_i,
		.cmd_data_i, .cmd_ready_o, .rsp_valid_o, .rsp_error_o,
		.rsp_data_o, .status_valid_o, .irq_o, .present_o, .bus(bus_if));
	lsc_chk u_lsc_chk (.clk_i, .reset_n_i, .scl(bus_if.scl),
		.interrupt_n(bus_if.interrupt_n),
		.module_present_n(bus_if.module_present_n),
		.init_control_select(bus_if.init_control_select),
		.module_select_n(bus_if.module_select_n),
		.module_reset_n(bus_if.module_reset_n),
		.host_init_oe(bus_if.host_init_oe), .dev_sda_oe(bus_if.dev_sda_oe),
		.dev_int_o(bus_if.dev_int_o), .dev_int_oe(bus_if.dev_int_oe));

	// ==========================================================
	// tasks
	task automatic end_sim;
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// request held until the edge that takes it, then answer awaited
	task automatic access(input logic w, input logic [7:0] idx,
		input logic [7:0] d, input logic [7:0] exp);
		while (cmd_ready_o !== 1'b1) tick(1);
		cmd_valid_i = 1'b1;
		cmd_write_i = w;
		cmd_index_i = idx;
		cmd_data_i = d;
		tick(1);
		cmd_valid_i = 1'b0;
		while (rsp_valid_o !== 1'b1) tick(1);
		chk(8'(rsp_error_o), 8'h00);
		if (!w) chk(rsp_data_o, exp);
	endtask

	// timeout cuts a hang short
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 100000) begin
			err_total++;
			end_sim();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		tick(10);
		reset_n_i = 1'b1;
		for (int i = 0; i < 600 && irq_o !== 1'b1; i++) tick(1);
		chk(8'(irq_o), 8'h01);
		chk(8'(present_o), 8'h01);
		access(1'b0, 8'h01, 8'h00, 8'h01);
		tick(4);
		chk(8'(irq_o), 8'h00);
		// fault only while the line is quiet, else it proves nothing
		fault_i = 1'b1;
		tick(1);
		fault_i = 1'b0;
		tick(4);
		chk(8'(irq_o), 8'h01);
		access(1'b0, 8'h00, 8'h00, 8'h04);
		chk(8'(low_power_select_o), 8'h01);
		access(1'b1, 8'h03, 8'hA5, 8'h00);
		access(1'b1, 8'h02, 8'h01, 8'h00);
		tick(3);
		chk(8'(low_power_select_o), 8'h00);
		reset_req_i = 1'b1;
		tick(1);
		reset_req_i = 1'b0;
		tick(2);
		chk(8'(status_valid_o), 8'h00);
		for (int i = 0; i < 6000 && status_valid_o !== 1'b1; i++) tick(1);
		chk(8'(status_valid_o), 8'h01);
		chk(8'(low_power_select_o), 8'h01);
		access(1'b0, 8'h03, 8'h00, 8'h00);
		// hardware init strap needs a fresh power-up of both ends
		hw_init_i = 1'b1;
		reset_n_i = 1'b0;
		tick(10);
		reset_n_i = 1'b1;
		for (int i = 0; i < 600 && low_power_select_o !== 1'b0; i++) tick(1);
		chk(8'(low_power_select_o), 8'h00);
		end_sim();
	end
endmodule
